// >>> core/swr_consts.vh
// Constants for the standby wake-up, NMI cause and reset cause block.
// Included by the design files; definitions only.
`ifndef SWR_CONSTS_VH
`define SWR_CONSTS_VH
// Register offsets (byte addresses)
`define SWR_ADDR_MODE_A 8'h00
`define SWR_ADDR_MODE_B 8'h04
`define SWR_ADDR_MODE_C 8'h08
`define SWR_ADDR_MODE_D 8'h0C
`define SWR_ADDR_CLEAR 8'h10
`define SWR_ADDR_NMI 8'h14
`define SWR_ADDR_RST 8'h18
`define SWR_ADDR_IRQ_STAT 8'h1C
`define SWR_ADDR_IRQ_EN 8'h20
`define SWR_ADDR_IRQ_CLR 8'h24
// Per-source byte layout inside a mode register
`define SWR_FLD_SEL_LSB 4
`define SWR_FLD_REC_LSB 2
`define SWR_FLD_EN_BIT 0
// Detection select codes
`define SWR_DET_LOW 3'h0
`define SWR_DET_HIGH 3'h1
`define SWR_DET_FALL 3'h2
`define SWR_DET_RISE 3'h3
`define SWR_DET_BOTH 3'h4
`define SWR_DET_RESET 3'h2
// Edge record codes
`define SWR_REC_NONE 2'h0
`define SWR_REC_RISE 2'h1
`define SWR_REC_FALL 2'h2
`define SWR_REC_BOTH 2'h3
// Clear-code field
`define SWR_CLR_W 5
`define SWR_NUM_SRC 16
// Flag widths and reset values
`define SWR_NMI_W 4
`define SWR_RST_W 7
`define SWR_RST_POWER_ON 7'h01
`define SWR_RST_PON_BIT 0
`define SWR_RST_DBG_BIT 4
// Interrupt status bits
`define SWR_IRQ_W 3
`define SWR_IRQ_WAKE 0
`define SWR_IRQ_NMI 1
`define SWR_IRQ_RST 2
`endif

// >>> core/swr_wake_src.v
// One wake source: detection select, edge record, enable and latched request.
// Assumes the source input is synchronous to mclk.
`timescale 1ns/100ps
`include "swr_consts.vh"
module swr_wake_src (
  mclk,
  rst,
  src_in,
  sel_we,
  sel_wdata,
  en_we,
  en_wdata,
  clr,
  sel_q,
  rec_q,
  en_q,
  pend_q,
  new_req
);
  input wire mclk;
  input wire rst;
  input wire src_in;
  input wire sel_we;
  input wire [2:0] sel_wdata;
  input wire en_we;
  input wire en_wdata;
  input wire clr;
  output reg [2:0] sel_q;
  output reg [1:0] rec_q;
  output reg en_q;
  output reg pend_q;
  output wire new_req;

  reg prev_q;
  reg hit;
  wire rise;
  wire fall;

  assign rise = src_in & ~prev_q;
  assign fall = ~src_in & prev_q;

  // [RULE_01] Detection by select
  always @* begin
    case (sel_q)
      `SWR_DET_LOW: hit = ~src_in;
      `SWR_DET_HIGH: hit = src_in;
      `SWR_DET_FALL: hit = fall;
      `SWR_DET_RISE: hit = rise;
      `SWR_DET_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
  end

  assign new_req = hit & ~pend_q;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_q <= `SWR_DET_RESET;
      rec_q <= `SWR_REC_NONE;
      en_q <= 1'b0;
      pend_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      prev_q <= src_in;
      if (sel_we)
        sel_q <= sel_wdata;
      // [RULE_05] Enable written apart
      if (en_we)
        en_q <= en_wdata;
      // [RULE_16] Latch until cleared
      if (hit)
        pend_q <= 1'b1;
      else if (clr)
        pend_q <= 1'b0;
      // [RULE_02] [RULE_03] Record edges in both-edge mode
      if (sel_q == `SWR_DET_BOTH && (rise | fall))
        rec_q <= rec_q | {fall, rise};
      // [RULE_04] Clear resets record
      else if (clr)
        rec_q <= `SWR_REC_NONE;
    end
  end
endmodule // swr_wake_src

// >>> core/swr_top.v
// Standby wake-up conditioning, NMI cause flags and reset cause flags.
// Assumes a single mclk domain, inputs synchronous to mclk, one-cycle strobes.
//
// Overview of operation
// [RULE_01] Three-bit select per source: low, high, fall, rise, both; 101-111 prohibited.
// [RULE_02] Two-bit edge record: 01 rising, 10 falling, 11 both edges.
// [RULE_03] Edge record is meaningful only in both-edges detection mode.
// [RULE_04] Clearing a request through the clear code also resets its edge record.
// [RULE_05] Software writes select first and enable in a later write.
// [RULE_06] Remote receive source may use only the rising-edge code.
// [RULE_07] Calendar clock source may use only the falling-edge code.
// [RULE_08] Five-bit clear code clears one source; upper codes reserved; reads zero.
// [RULE_09] Four NMI cause flags: watchdog, pin, below and above voltage.
// [RULE_10] Reading NMI cause flags returns them and clears all four.
// [RULE_11] One held reset cause flag per reset source, bits 0 to 6.
// [RULE_12] Reset flags never self-clear; software writes zero to clear.
// [RULE_13] Debug flag sets on the core system reset request.
// [RULE_14] Power-up sets power-on flag; later resets set their own flag.
// [RULE_15] After power-up other reset flags are undefined and invalid.
// [RULE_16] Requests latch until cleared; wake output only when enabled.
`timescale 1ns/100ps
`include "swr_consts.vh"
module swr_top #(
  parameter NUM_SRC = `SWR_NUM_SRC
) (
  mclk,
  rst,
  por,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  wake_src_in,
  nmi_event,
  rst_event,
  core_system_reset_request,
  wake_release,
  wake_pending,
  irq
);
  input wire mclk;
  input wire rst;
  input wire por;
  input wire [7:0] reg_addr;
  input wire [31:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [31:0] reg_rdata;
  input wire [NUM_SRC-1:0] wake_src_in;
  input wire [`SWR_NMI_W-1:0] nmi_event;
  input wire [`SWR_RST_W-1:0] rst_event;
  input wire core_system_reset_request;
  output wire wake_release;
  output wire [NUM_SRC-1:0] wake_pending;
  output wire irq;

  wire [NUM_SRC*3-1:0] sel_all;
  wire [NUM_SRC*2-1:0] rec_all;
  wire [NUM_SRC-1:0] en_all;
  wire [NUM_SRC-1:0] new_all;
  wire [NUM_SRC*8-1:0] mode_bytes;
  wire [NUM_SRC-1:0] clr_vec;
  wire clr_hit;
  reg [`SWR_NMI_W-1:0] nmi_q;
  reg [`SWR_RST_W-1:0] rst_flag_q;
  reg [`SWR_RST_W-1:0] rst_seen_q;
  reg [`SWR_IRQ_W-1:0] irq_stat_q;
  reg [`SWR_IRQ_W-1:0] irq_en_q;
  reg [31:0] rdata_d;
  wire [`SWR_RST_W-1:0] rst_set;
  wire nmi_rd;
  wire [`SWR_IRQ_W-1:0] irq_ev;

  assign clr_hit = reg_wr && reg_addr == `SWR_ADDR_CLEAR;

  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i = i + 1) begin : g_src
      wire [31:0] sel_off;
      wire [7:0] sel_addr;
      wire wr_this;
      assign sel_off = (i / 4) * 4;
      assign sel_addr = `SWR_ADDR_MODE_A + sel_off[7:0];
      assign wr_this = reg_wr && reg_addr == sel_addr;
      // [RULE_08] Clear code decode
      assign clr_vec[i] = clr_hit && reg_wdata[`SWR_CLR_W-1:0] == i;
      swr_wake_src u_src (
        .mclk(mclk),
        .rst(rst),
        .src_in(wake_src_in[i]),
        .sel_we(wr_this),
        .sel_wdata(reg_wdata[(i%4)*8+`SWR_FLD_SEL_LSB +: 3]),
        .en_we(wr_this),
        .en_wdata(reg_wdata[(i%4)*8+`SWR_FLD_EN_BIT]),
        .clr(clr_vec[i]),
        .sel_q(sel_all[i*3 +: 3]),
        .rec_q(rec_all[i*2 +: 2]),
        .en_q(en_all[i]),
        .pend_q(wake_pending[i]),
        .new_req(new_all[i])
      );
      assign mode_bytes[i*8 +: 8] = {1'b0, sel_all[i*3 +: 3], rec_all[i*2 +: 2], 1'b0, en_all[i]};
    end
  endgenerate

  // [RULE_16] Gate by enable
  assign wake_release = |(wake_pending & en_all);

  assign nmi_rd = reg_rd && reg_addr == `SWR_ADDR_NMI;
  // [RULE_13] Debug reset source
  assign rst_set = rst_event | ({{(`SWR_RST_W-1){1'b0}}, core_system_reset_request} << `SWR_RST_DBG_BIT);
  assign irq_ev = {|rst_set, |nmi_event, |new_all};
  assign irq = |(irq_stat_q & irq_en_q);

  always @* begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      `SWR_ADDR_MODE_A: rdata_d = mode_bytes[31:0];
      `SWR_ADDR_MODE_B: rdata_d = mode_bytes[63:32];
      `SWR_ADDR_MODE_C: rdata_d = mode_bytes[95:64];
      `SWR_ADDR_MODE_D: rdata_d = mode_bytes[127:96];
      `SWR_ADDR_NMI: rdata_d[`SWR_NMI_W-1:0] = nmi_q;
      `SWR_ADDR_RST: rdata_d[`SWR_RST_W-1:0] = rst_flag_q;
      `SWR_ADDR_IRQ_STAT: rdata_d[`SWR_IRQ_W-1:0] = irq_stat_q;
      `SWR_ADDR_IRQ_EN: rdata_d[`SWR_IRQ_W-1:0] = irq_en_q;
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
      nmi_q <= {`SWR_NMI_W{1'b0}};
      irq_stat_q <= {`SWR_IRQ_W{1'b0}};
      irq_en_q <= {`SWR_IRQ_W{1'b0}};
    end else begin
      reg_rdata <= reg_rd ? rdata_d : 32'h00000000;
      // [RULE_09] [RULE_10] Set wins over read clear
      if (nmi_rd)
        nmi_q <= nmi_event;
      else
        nmi_q <= nmi_q | nmi_event;
      if (reg_wr && reg_addr == `SWR_ADDR_IRQ_EN)
        irq_en_q <= reg_wdata[`SWR_IRQ_W-1:0];
      if (reg_wr && reg_addr == `SWR_ADDR_IRQ_CLR)
        irq_stat_q <= (irq_stat_q & ~reg_wdata[`SWR_IRQ_W-1:0]) | irq_ev;
      else
        irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  // Reset flags live on the power-on reset only, so ordinary resets are recorded
  always @(posedge mclk or posedge por) begin
    if (por) begin
      // [RULE_14] [RULE_15] Power-on value
      rst_flag_q <= `SWR_RST_POWER_ON;
      rst_seen_q <= {`SWR_RST_W{1'b0}};
    end else begin
      rst_seen_q <= rst_set;
      // [RULE_11] [RULE_12] Hold until zero written
      if (reg_wr && reg_addr == `SWR_ADDR_RST)
        rst_flag_q <= (rst_flag_q & reg_wdata[`SWR_RST_W-1:0]) | (rst_set & ~rst_seen_q);
      else
        rst_flag_q <= rst_flag_q | (rst_set & ~rst_seen_q);
    end
  end
endmodule // swr_top

// >>> verif/swr_top_assertions.sv
// Checker for swr_top: read port, wake latch, flag and irq behaviour.
// Bound to swr_top; sees its ports only.
`timescale 1ns/100ps
module swr_chk #(
  parameter NUM_SRC = 16
) (
  input wire mclk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [3:0] nmi_event,
  input wire wake_release,
  input wire [NUM_SRC-1:0] wake_pending,
  input wire irq
);
  reg [NUM_SRC-1:0] pend_q;
  wire [NUM_SRC-1:0] fell = pend_q & ~wake_pending;
  always @(posedge mclk or posedge rst) begin
    if (rst) pend_q <= {NUM_SRC{1'b0}};
    else pend_q <= wake_pending;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_nmi_rd;
    reg_rd && reg_addr == 8'h14 && nmi_event == 0 && $past(nmi_event) == 0;
  endsequence
  sequence s_rst_rd;
    reg_rd && reg_addr == 8'h18;
  endsequence
  property p_rd_idle; !reg_rd |=> reg_rdata == 0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
  property p_clr_rd0; reg_rd && reg_addr == 8'h10 |=> reg_rdata == 0; endproperty
  a_clr_rd0: assert property (p_clr_rd0) else $error("clear reg reads nonzero");
  property p_nmi_clr; s_nmi_rd ##1 s_nmi_rd |=> reg_rdata == 0; endproperty
  a_nmi_clr: assert property (p_nmi_clr) else $error("nmi flags not cleared");
  property p_rel_none; wake_pending == 0 |-> !wake_release; endproperty
  a_rel_none: assert property (p_rel_none) else $error("release without request");
  property p_pend_hold; |fell |-> $past(reg_wr && reg_addr == 8'h10 && !reg_wdata[4]); endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("request dropped");
  property p_clr_one; |fell |-> fell == (1 << $past(reg_wdata[3:0])); endproperty
  a_clr_one: assert property (p_clr_one) else $error("wrong request cleared");
  property p_irq_fall; $fell(irq) |-> $past(reg_wr && (reg_addr == 8'h20 || reg_addr == 8'h24)); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  property p_rst_hold;
    s_rst_rd ##1 s_rst_rd |=> (reg_rdata[6:0] & $past(reg_rdata[6:0])) == $past(reg_rdata[6:0]);
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset flag self-cleared");
endmodule // swr_chk
bind swr_top swr_chk #(.NUM_SRC(NUM_SRC)) i_swr_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_event(nmi_event),
  .wake_release(wake_release), .wake_pending(wake_pending), .irq(irq));

// >>> verif/tb.sv
// Self-checking bench for swr_top through its register port.
// Bench drives every input; checker is bound to swr_top.
`timescale 1ns/100ps
module tb;
  reg mclk = 0, rst = 1, por = 1, reg_wr = 0, reg_rd = 0, csr = 0;
  reg [7:0] reg_addr = 0;
  reg [31:0] reg_wdata = 0;
  reg [15:0] src = 0;
  reg [3:0] nmi = 0;
  reg [6:0] rev = 0;
  wire [31:0] reg_rdata;
  wire [15:0] pend;
  wire rel, irq;
  integer mismatches = 0, n_compared = 0, i;
  swr_top i_swr_top (.mclk(mclk), .rst(rst), .por(por), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_src_in(src), .nmi_event(nmi),
    .rst_event(rev), .core_system_reset_request(csr), .wake_release(rel), .wake_pending(pend), .irq(irq));
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0t seen %h exp %h", $time, s, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 0;
      @(negedge mclk);
    end
  endtask
  // Two back-to-back reads, each result masked and compared
  task rd(input [7:0] a, input [31:0] m, input [31:0] e1, input [31:0] e2);
    begin
      @(posedge mclk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge mclk);
      @(negedge mclk);
      chk(reg_rdata & m, e1);
      @(posedge mclk);
      reg_rd <= 0;
      @(negedge mclk);
      chk(reg_rdata & m, e2);
    end
  endtask
  task step(input [15:0] s);
    begin
      @(posedge mclk);
      src <= s;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
    end
  endtask
  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    forever #10 mclk = ~mclk;
  end
  initial begin
    #1000000 mismatches = mismatches + 1;
    conclude;
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 0; por <= 0;
    rd(8'h18, 32'hFFFFFF81, 1, 1);
    rd(8'h10, -1, 0, 0);
    rd(8'h08, -1, 32'h20202020, 32'h20202020);
    rd(8'h40, -1, 0, 0);
    $display("test reset done");
    wr(8'h00, 32'h20202040);
    wr(8'h00, 32'h20202041);
    step(1);
    chk({pend, 15'h0, rel}, 32'h00010001);
    rd(8'h00, -1, 32'h20202045, 32'h20202045);
    wr(8'h10, 32'h10);
    chk(pend, 1);
    wr(8'h10, 0);
    chk(pend, 0);
    rd(8'h00, -1, 32'h20202041, 32'h20202041);
    step(0);
    rd(8'h00, -1, 32'h20202049, 32'h20202049);
    step(1);
    rd(8'h00, -1, 32'h2020204D, 32'h2020204D);
    wr(8'h00, 32'h20202040);
    chk({pend, 15'h0, rel}, 32'h00010000);
    wr(8'h10, 0);
    wr(8'h0C, 32'h30202020);
    rd(8'h0C, -1, 32'h30202020, 32'h30202020);
    $display("test wake done");
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge mclk);
      nmi <= 4'h5 << i;
      @(posedge mclk);
      nmi <= 0;
      rd(8'h14, -1, 32'h5 << i, 0);
    end
    wr(8'h18, 0);
    rd(8'h18, -1, 0, 0);
    for (i = 1; i < 7; i = i + 1) begin
      @(posedge mclk);
      rev <= 7'h1 << i;
      @(posedge mclk);
      rev <= 0;
      rd(8'h18, -1, 32'h1 << i, 32'h1 << i);
      wr(8'h18, 0);
    end
    @(posedge mclk);
    csr <= 1;
    @(posedge mclk);
    csr <= 0;
    rd(8'h18, -1, 32'h10, 32'h10);
    $display("test flags done");
    rd(8'h1C, -1, 7, 7);
    chk(irq, 0);
    wr(8'h20, 7);
    chk(irq, 1);
    wr(8'h24, 7);
    chk(irq, 0);
    rd(8'h1C, -1, 0, 0);
    $display("test irq done");
    conclude;
  end
endmodule // tb
